// file: acs_sequencer.v
// Conversion sequencer: trigger modes, channel select and scan, timing, Wishbone slave
// Function
// - 12-bit results, 21 external channels addressable
// - Software start begins conversion immediately
// - Hardware trigger starts powered converter immediately
// - Wait mode: trigger powers up, then converts
// - Select mode converts one chosen channel
// - Scan converts four consecutive channels, first sixteen
// - Single mode converts once per start
// - Continuous mode repeats until software stops
// - Sample/convert clocks programmable, default 13.5/31.5
// - Internal reference and temperature sensor selectable
// - Self-test sources: reference rails, channel, sensors
// - Both gain amplifier outputs selectable
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"
module acs_sequencer #(
  parameter RES_W = 12
) (
  input  wire             clk,
  input  wire             nrst,
  // Wishbone classic slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // Hardware trigger sources, asynchronous to clk
  input  wire [3:0]       hw_trig,
  // Converter core
  input  wire             conv_done,
  input  wire [RES_W-1:0] conv_data,
  output reg  [4:0]       analog_input_channel,
  output reg              conv_power,
  output reg              conv_sample,
  output reg              conv_start,
  output reg              conv_done_evt
);
  // --------------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_STAB = 6'h02;
  localparam [5:0] ST_SAMP = 6'h04;
  localparam [5:0] ST_CONV = 6'h08;
  localparam [5:0] ST_WAIT = 6'h10;
  localparam [5:0] ST_NEXT = 6'h20;
  localparam integer STAB_CYC_I = (`ACS_STAB_TIME_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;
  localparam [7:0] STAB_CYC = STAB_CYC_I[7:0];

  // Half-clock count rounded up to whole clocks
  function [7:0] half_to_cyc;
    input [7:0] h;
    begin
      half_to_cyc = {1'b0, h[7:1]} + {7'h00, h[0]};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [1:0]  trg_mode_q;
  reg        scan_q;
  reg        cont_q;
  reg [1:0]  trg_src_q;
  reg        pwr_en_q;
  reg [4:0]  ch_sel_q;
  reg [7:0]  samp_q;
  reg [7:0]  conv_q;
  reg [5:0]  st_q;
  reg [7:0]  cnt_q;
  reg [1:0]  scan_idx_q;
  reg [RES_W-1:0] result_q;
  reg        overrun_q;
  reg        done_flag_q;
  reg [3:0]  trg_s1_q;
  reg [3:0]  trg_s2_q;
  reg        trg_prev_q;
  reg        run_q;

  reg        rd_wait_q;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~rd_wait_q;
  // Scan store reads take one extra cycle: the store has a registered read port
  wire scan_rd  = wb_req & ~wb_we_i & ((wb_adr_i & `ACS_SCANRES_MASK) == `ACS_OFF_SCANRES);
  wire wb_wr  = wb_req & wb_we_i;
  wire wr_ctrl = wb_wr & (wb_adr_i == `ACS_OFF_CTRL) & wb_sel_i[0];
  wire sw_start = wr_ctrl & wb_dat_i[`ACS_CTRL_START];
  wire sw_stop  = wr_ctrl & wb_dat_i[`ACS_CTRL_STOP];
  wire stat_rd  = wb_req & ~wb_we_i & (wb_adr_i == `ACS_OFF_STATUS);

  // --------------------------------------------------------------------------
  // Trigger synchroniser and edge detect
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trg_s1_q   <= 4'h0;
      trg_s2_q   <= 4'h0;
      trg_prev_q <= 1'b0;
    end else begin
      trg_s1_q   <= hw_trig;
      trg_s2_q   <= trg_s1_q;
      trg_prev_q <= trg_s2_q[trg_src_q];
    end
  end
  wire hw_edge = trg_s2_q[trg_src_q] & ~trg_prev_q & (trg_mode_q != `ACS_TRG_SOFT);
  // A start written together with new mode bits must already use them
  wire scan_now = (wr_ctrl && st_q == ST_IDLE) ? wb_dat_i[`ACS_CTRL_SCAN] : scan_q;
  wire go_samp  = (st_q == ST_IDLE) & (sw_start | (hw_edge & (trg_mode_q == `ACS_TRG_HW_NOWAIT) & pwr_en_q));
  wire go_stab  = (st_q == ST_IDLE) & ~sw_start & hw_edge & (trg_mode_q == `ACS_TRG_HW_WAIT);

  // Scan base restricted so the group of four stays within the first sixteen
  wire [4:0] scan_base = (ch_sel_q > `ACS_CH_SCAN_LAST) ? `ACS_CH_SCAN_LAST : ch_sel_q;
  wire [4:0] cur_ch    = scan_now ? (scan_base + {3'h0, scan_idx_q}) : ch_sel_q;

  // --------------------------------------------------------------------------
  // Result store for scan sets
  // --------------------------------------------------------------------------
  wire [RES_W-1:0] mem_rd;
  acs_result_mem #(.WIDTH(RES_W), .DEPTH(4), .AW(2)) u_mem (
    .clk   (clk),
    .we    (st_q == ST_WAIT && conv_done),
    .waddr (scan_idx_q),
    .wdata (conv_data),
    .raddr (wb_adr_i[3:2]),
    .rdata (mem_rd)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q          <= ST_IDLE;
      cnt_q         <= 8'h00;
      scan_idx_q    <= 2'h0;
      result_q      <= {RES_W{1'b0}};
      run_q         <= 1'b0;
      conv_power    <= 1'b0;
      conv_sample   <= 1'b0;
      conv_start    <= 1'b0;
      conv_done_evt <= 1'b0;
      analog_input_channel <= `ACS_CH_RESET;
      overrun_q     <= 1'b0;
      done_flag_q   <= 1'b0;
    end else begin
      conv_start    <= 1'b0;
      conv_done_evt <= 1'b0;
      if (stat_rd) begin
        done_flag_q <= 1'b0;
        overrun_q   <= 1'b0;
      end
      // Wait mode keeps the core off while idle; a start powers it up in the same edge
      conv_power <= (trg_mode_q == `ACS_TRG_HW_WAIT) ? (st_q != ST_IDLE || go_stab || go_samp) :
                    (pwr_en_q || st_q != ST_IDLE || go_samp);
      case (st_q)
        ST_IDLE: begin
          scan_idx_q <= 2'h0;
          if (go_samp) begin
            run_q <= 1'b1;
            analog_input_channel <= cur_ch;
            cnt_q <= half_to_cyc(samp_q);
            conv_sample <= 1'b1;
            st_q  <= ST_SAMP;
          end else if (go_stab) begin
            run_q <= 1'b1;
            cnt_q <= STAB_CYC;
            st_q  <= ST_STAB;
          end
        end
        ST_STAB: begin
          if (cnt_q <= 8'h01) begin
            analog_input_channel <= cur_ch;
            cnt_q <= half_to_cyc(samp_q);
            conv_sample <= 1'b1;
            st_q  <= ST_SAMP;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_SAMP: begin
          if (cnt_q <= 8'h01) begin
            conv_sample <= 1'b0;
            conv_start  <= 1'b1;
            cnt_q <= half_to_cyc(conv_q);
            st_q  <= ST_CONV;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_CONV: begin
          if (cnt_q <= 8'h01) begin
            st_q <= ST_WAIT;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_WAIT: begin
          if (conv_done) begin
            result_q      <= conv_data;
            conv_done_evt <= 1'b1;
            done_flag_q   <= 1'b1;
            st_q          <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (scan_q && scan_idx_q != 2'h3) begin
            scan_idx_q <= scan_idx_q + 2'h1;
            st_q <= ST_IDLE;
            run_q <= 1'b1;
          end
          if (!run_q || (!cont_q && !(scan_q && scan_idx_q != 2'h3))) begin
            st_q  <= ST_IDLE;
            run_q <= 1'b0;
          end else begin
            if (!(scan_q && scan_idx_q != 2'h3)) begin
              scan_idx_q <= 2'h0;
            end
            // Index wraps from the last channel of the group back to the base
            analog_input_channel <= scan_q ? (scan_base + {3'h0, scan_idx_q + 2'h1}) : ch_sel_q;
            cnt_q <= half_to_cyc(samp_q);
            conv_sample <= 1'b1;
            st_q  <= ST_SAMP;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (sw_stop) begin
        run_q <= 1'b0;
      end
      // Triggers while busy are dropped; only an indication is kept
      if (hw_edge && st_q != ST_IDLE) begin
        overrun_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trg_mode_q <= `ACS_TRG_SOFT;
      scan_q     <= 1'b0;
      cont_q     <= 1'b0;
      trg_src_q  <= 2'h0;
      pwr_en_q   <= 1'b0;
      ch_sel_q   <= `ACS_CH_RESET;
      samp_q     <= `ACS_SAMP_RESET;
      conv_q     <= `ACS_CONV_RESET;
    end else if (wb_wr && st_q == ST_IDLE) begin
      // Mode changes only land while idle so a running sequence stays coherent
      case (wb_adr_i)
        `ACS_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            trg_mode_q <= wb_dat_i[`ACS_CTRL_TRG_HI:`ACS_CTRL_TRG_LO];
            scan_q     <= wb_dat_i[`ACS_CTRL_SCAN];
            cont_q     <= wb_dat_i[`ACS_CTRL_CONT];
          end
          if (wb_sel_i[1]) begin
            trg_src_q  <= wb_dat_i[`ACS_CTRL_TSRC_HI:`ACS_CTRL_TSRC_LO];
            pwr_en_q   <= wb_dat_i[`ACS_CTRL_PWR];
          end
        end
        `ACS_OFF_CHSEL: begin
          if (wb_sel_i[0] && wb_dat_i[4:0] <= `ACS_CH_REF_NEG) begin
            ch_sel_q <= wb_dat_i[4:0];
          end
        end
        `ACS_OFF_TIMING: begin
          if (wb_sel_i[0] && wb_dat_i[7:0] != 8'h00) begin
            samp_q <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1] && wb_dat_i[15:8] != 8'h00) begin
            conv_q <= wb_dat_i[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bus answer: two cycles for scan store reads, ack one cycle after request
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o  <= 1'b0;
      rd_wait_q <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else begin
      wb_ack_o  <= rd_wait_q | (wb_req & ~scan_rd);
      rd_wait_q <= scan_rd;
      wb_dat_o  <= 32'h0000_0000;
      if (rd_wait_q) begin
        wb_dat_o <= {{(32-RES_W){1'b0}}, mem_rd};
      end else if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `ACS_OFF_CTRL:   wb_dat_o <= {21'h0, pwr_en_q, trg_src_q, 2'h0, cont_q, scan_q,
                                        trg_mode_q, 2'h0};
          `ACS_OFF_CHSEL:  wb_dat_o <= {27'h0, ch_sel_q};
          `ACS_OFF_TIMING: wb_dat_o <= {16'h0, conv_q, samp_q};
          `ACS_OFF_STATUS: wb_dat_o <= {26'h0, scan_idx_q, overrun_q, done_flag_q,
                                        conv_power, (st_q != ST_IDLE)};
          `ACS_OFF_RESULT: wb_dat_o <= {{(32-RES_W){1'b0}}, result_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // acs_sequencer
`default_nettype wire

// file: acs_consts.vh
// Constants for the conversion sequencer: register map, fields, reset values, timing
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ACS_OFF_CTRL      8'h00
`define ACS_OFF_CHSEL     8'h04
`define ACS_OFF_TIMING    8'h08
`define ACS_OFF_STATUS    8'h0c
`define ACS_OFF_RESULT    8'h10
`define ACS_OFF_SCANRES   8'h20
`define ACS_SCANRES_MASK  8'hf0

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define ACS_CTRL_START    0
`define ACS_CTRL_STOP     1
`define ACS_CTRL_TRG_LO   2
`define ACS_CTRL_TRG_HI   3
`define ACS_CTRL_SCAN     4
`define ACS_CTRL_CONT     5
`define ACS_CTRL_TSRC_LO  8
`define ACS_CTRL_TSRC_HI  9
`define ACS_CTRL_PWR      10

// Trigger modes
`define ACS_TRG_SOFT      2'h0
`define ACS_TRG_HW_NOWAIT 2'h1
`define ACS_TRG_HW_WAIT   2'h2

// ----------------------------------------------------------------------------
// Channel codes: 0..20 external, then internal sources
// ----------------------------------------------------------------------------
`define ACS_CH_EXT_LAST   5'h14
`define ACS_CH_SCAN_LAST  5'h0c
`define ACS_CH_TEMP       5'h15
`define ACS_CH_VREF_INT   5'h16
`define ACS_CH_GAIN_A     5'h17
`define ACS_CH_GAIN_B     5'h18
`define ACS_CH_REF_POS    5'h19
`define ACS_CH_REF_NEG    5'h1a
`define ACS_CH_RESET      5'h00

// ----------------------------------------------------------------------------
// Timing: sample/convert in half clocks (13.5 clk = 27, 31.5 clk = 63), stabilise time and clock period in ns
// ----------------------------------------------------------------------------
`define ACS_SAMP_RESET    8'h1b
`define ACS_CONV_RESET    8'h3f
`define ACS_STAB_TIME_NS  1000
`define ACS_CLK_PERIOD_NS 100

`endif

// file: acs_result_mem.v
// Four-word result store for the conversion sequencer, registered read port
`timescale 1ns/1ps
`default_nettype none
module acs_result_mem #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // acs_result_mem
`default_nettype wire

// file: acs_core_model.sv
// Behavioural converter core that answers each start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module acs_core_model #(
  parameter int DLY = 34
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        conv_start,
  input  wire logic [4:0]  analog_input_channel,
  output var  logic        conv_done,
  output var  logic [11:0] conv_data
);
  int          cnt_q;
  logic [11:0] res_q;
  // Data toggles outside the done pulse so a late sample cannot pass by luck
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q     <= 0;
      res_q     <= 12'h000;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        cnt_q <= slow ? DLY + 20 : DLY;
        res_q <= {7'h35, analog_input_channel};
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          conv_done <= 1'b1;
          conv_data <= res_q;
        end
      end
    end
  end
endmodule // acs_core_model
`default_nettype wire

// file: acs_sequencer_sva.sv
// Port-level checks on the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"
module acs_sequencer_sva (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic       conv_done,
  input wire logic [4:0] analog_input_channel,
  input wire logic       conv_power,
  input wire logic       conv_sample,
  input wire logic       conv_start,
  input wire logic       conv_done_evt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire scan_sel = !wb_we_i && ((wb_adr_i & `ACS_SCANRES_MASK) == `ACS_OFF_SCANRES);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !scan_sel;
  endsequence
  sequence s_scan_req;
    $rose(wb_stb_i) && wb_cyc_i && scan_sel;
  endsequence
  sequence s_late_ack;
    !wb_ack_o ##1 wb_ack_o;
  endsequence
  a_ack_scan_read: assert property (s_scan_req |=> s_late_ack)
    else $error("scan store read not answered in its second cycle");
  sequence s_quiet;
    !conv_sample [*4];
  endsequence
  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_start_ends_sample: assert property (conv_start |-> $past(conv_sample))
    else $error("start pulse without sampling before it");
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_evt_after_done: assert property (conv_done_evt |-> $past(conv_done))
    else $error("done event without core completion");
  a_evt_single: assert property (conv_done_evt |=> !conv_done_evt)
    else $error("done event longer than one cycle");
  a_sample_powered: assert property (conv_sample |-> conv_power)
    else $error("sampling while converter unpowered");
  a_channel_legal: assert property (conv_sample |-> analog_input_channel <= 5'h1a)
    else $error("channel code out of range");
  a_channel_held: assert property (conv_sample && $past(conv_sample) |-> $stable(analog_input_channel))
    else $error("channel changed while sampling");
  a_conv_undisturbed: assert property (conv_start |=> s_quiet)
    else $error("sampling restarted during conversion");
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva u_sva (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .conv_done(conv_done), .analog_input_channel(analog_input_channel), .conv_power(conv_power),
  .conv_sample(conv_sample), .conv_start(conv_start), .conv_done_evt(conv_done_evt)
);
`default_nettype wire

// file: test_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"
module test_adc_conversion_sequencer;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, slow = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wd = 0, rd, q;
  logic [3:0]  trg = 0;
  logic        ack, smp, st, pwr, evt, cdone;
  logic [11:0] cdat;
  logic [4:0]  ch;
  logic [4:0]  chs[$];
  int          mismatches = 0, n_compared = 0, nev = 0, slen = 0, scur = 0;
  acs_sequencer dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .hw_trig(trg),
    .conv_done(cdone), .conv_data(cdat), .analog_input_channel(ch), .conv_power(pwr),
    .conv_sample(smp), .conv_start(st), .conv_done_evt(evt));
  acs_core_model core (.clk(clk), .nrst(nrst), .slow(slow), .conv_start(st),
    .analog_input_channel(ch), .conv_done(cdone), .conv_data(cdat));
  initial forever #50 clk = ~clk;
  // Count by non-blocking update so tasks reading at the edge see a settled value
  always @(posedge clk) begin
    if (st === 1'b1) chs.push_back(ch);
    if (evt === 1'b1) nev <= nev + 1;
    // Length of the last sampling window, in clocks
    if (smp === 1'b1) begin
      scur <= scur + 1;
    end else if (scur > 0) begin
      slen <= scur;
      scur <= 0;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    q = rd;
    chk("bus ack", 1'b1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Raise a trigger and count clocks until sampling shows
  task automatic trig_lat(input logic [3:0] p, output int w);
    w = 0;
    trg <= p;
    while (smp !== 1'b1 && w < 40) begin
      @(posedge clk);
      w++;
    end
    trg <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_ev(input int n);
    int t;
    t = 0;
    while (nev < n && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk("event count", n, nev);
  endtask
  task automatic pulse(input logic [3:0] p);
    trg <= p;
    repeat (3) @(posedge clk);
    trg <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset;
    chk("idle outputs", 5'h00, {pwr, smp, st, evt, ack});
    bus(0, `ACS_OFF_TIMING, 0);
    chk("timing reset", {16'h0, `ACS_CONV_RESET, `ACS_SAMP_RESET}, q);
    bus(0, 8'h30, 0);
    chk("unmapped read", 32'h0, q);
  endtask
  task automatic t_select;
    logic [4:0] cl[8];
    int e;
    cl = '{5'h00, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1a};
    foreach (cl[i]) begin
      e = nev + 1;
      chs.delete();
      bus(1, `ACS_OFF_CHSEL, {27'h0, cl[i]});
      bus(1, `ACS_OFF_CTRL, 32'h401);
      wait_ev(e);
      chk("sample clocks", 14, slen);
      chk("start count", 1, chs.size());
      chk("channel", cl[i], chs[0]);
      bus(0, `ACS_OFF_RESULT, 0);
      chk("result", {20'h0, 7'h35, cl[i]}, q);
    end
    repeat (150) @(posedge clk);
    chk("single stops", e, nev);
  endtask
  task automatic t_scan;
    int e;
    slow <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      e = nev + 4;
      chs.delete();
      bus(1, `ACS_OFF_CHSEL, k ? 32'h0f : 32'h05);
      bus(1, `ACS_OFF_CTRL, 32'h411);
      wait_ev(e);
      for (int i = 0; i < 4; i++) begin
        chk("scan channel", (k ? 12 : 5) + i, chs[i]);
        bus(0, 8'(`ACS_OFF_SCANRES + 4 * i), 0);
        chk("scan store", {20'h0, 7'h35, 5'((k ? 12 : 5) + i)}, q);
      end
    end
    slow <= 1'b0;
  endtask
  task automatic t_cont;
    int e;
    e = nev + 3;
    bus(1, `ACS_OFF_CTRL, 32'h421);
    wait_ev(e);
    bus(1, `ACS_OFF_CTRL, 32'h2);
    repeat (100) @(posedge clk);
    e = nev;
    repeat (200) @(posedge clk);
    chk("stopped", e, nev);
  endtask
  task automatic t_timing;
    int e;
    e = nev + 1;
    bus(1, `ACS_OFF_TIMING, 32'h0a05);
    bus(1, `ACS_OFF_CTRL, 32'h401);
    wait_ev(e);
    chk("programmed sample", 3, slen);
  endtask
  task automatic t_hw;
    int w, e;
    e = nev + 1;
    bus(1, `ACS_OFF_CTRL, 32'h604);
    pulse(4'h2);
    repeat (40) @(posedge clk);
    chk("other source ignored", e - 1, nev);
    // Two synchroniser stages, one registered output, one sampling edge in the bench
    trig_lat(4'h4, w);
    chk("trigger latency", 4, w);
    pulse(4'h4);
    repeat (150) @(posedge clk);
    chk("busy trigger ignored", e, nev);
    bus(0, `ACS_OFF_STATUS, 0);
    chk("status flags", 32'h0e, q);
    bus(0, `ACS_OFF_STATUS, 0);
    chk("status cleared", 32'h02, q);
  endtask
  task automatic t_wait;
    int w, e;
    e = nev + 1;
    bus(1, `ACS_OFF_CTRL, 32'h208);
    repeat (5) @(posedge clk);
    chk("standby power", 1'b0, pwr);
    trig_lat(4'h4, w);
    chk("stabilise wait", 4 + `ACS_STAB_TIME_NS / `ACS_CLK_PERIOD_NS, w);
    wait_ev(e);
    repeat (3) @(posedge clk);
    chk("standby after", 1'b0, pwr);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_select;
    t_scan;
    t_cont;
    t_timing;
    t_hw;
    t_wait;
    stop_test;
  end
  initial begin
    #2000000;
    mismatches++;
    stop_test;
  end
endmodule // test_adc_conversion_sequencer
`default_nettype wire
